// *** hcur_overlay.v ***
// Operation
// - each shape is 64x64, one bit per pixel
// - word low half shape zero, high half one
// - at retrace, check cursor covers next scanline
// - fetch eight words per burst into RAM
// - linear addresses, lines sixteen bytes apart
// - two bit-pair to colour mapping conventions
// - pattern base is bits 23:0
// - position is bottom-right, range 0..2047
// - x in 10:0, y in 26:16
// - clip partial cursor at every screen edge
// - colour zero: blue, green, red bytes
// - colour one same layout, for one-pairs
// - overlay and fetch only while enabled
`timescale 1ns/1ps
`include "hcur_defines.vh"

module hcur_overlay (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [4:0]   avs_address_i,
  input  wire         avs_read_i,
  input  wire         avs_write_i,
  input  wire [31:0]  avs_writedata_i,
  input  wire [3:0]   avs_byteenable_i,
  output wire [31:0]  avs_readdata_o,
  output wire         avs_waitrequest_o,
  input  wire         hretrace_i,
  input  wire [10:0]  next_line_i,
  output wire         mem_read_o,
  output wire [23:0]  mem_address_o,
  output wire [3:0]   mem_burstcount_o,
  input  wire         mem_waitrequest_i,
  input  wire [127:0] mem_readdata_i,
  input  wire         mem_readdatavalid_i,
  input  wire         pix_valid_i,
  input  wire [10:0]  pix_x_i,
  input  wire [23:0]  pix_rgb_i,
  output wire         pix_valid_o,
  output wire [23:0]  pix_rgb_o
);

  // fetch state machine codes
  localparam ST_IDLE = 2'b00;
  localparam ST_REQ  = 2'b01;
  localparam ST_DATA = 2'b10;

  // software visible registers
  reg  [31:0]  pat_base_reg;
  reg  [31:0]  position_reg;
  reg  [31:0]  colour0_reg;
  reg  [31:0]  colour1_reg;
  reg  [31:0]  control_reg;
  reg  [31:0]  rdata_reg;
  reg          rd_ack_reg;

  // fetch machinery
  reg  [1:0]   state_reg;
  reg  [1:0]   state_next;
  reg          mem_read_reg;
  reg  [23:0]  mem_addr_reg;
  reg  [2:0]   wcnt_reg;
  reg          buf_valid_reg;
  reg  [2:0]   buf_group_reg;
  reg          retrace_d_reg;

  // per-line state latched at retrace
  reg          line_hit_reg;
  reg  [5:0]   line_idx_reg;

  // pixel output stage
  reg          pix_valid_reg;
  reg  [23:0]  pix_rgb_reg;

  wire [31:0]  be_mask;
  wire [127:0] ram_word;
  wire         enable;
  wire         xmode;
  wire [10:0]  pos_x;
  wire [10:0]  pos_y;
  wire [23:0]  colour0;
  wire [23:0]  colour1;
  wire [23:0]  pat_base;
  wire         retrace_rise;
  wire [10:0]  dy;
  wire         line_cover;
  wire [5:0]   line_idx;
  wire [2:0]   line_group;
  wire         need_fetch;
  wire         wr_sel;
  wire         rd_sel;
  wire         ram_we;
  wire [10:0]  dx;
  wire         col_cover;
  wire [5:0]   col_idx;
  wire         bit_s0;
  wire         bit_s1;
  wire         show;
  reg  [23:0]  mix_rgb;

  // field extraction
  assign enable   = control_reg[`HCUR_CTRL_ENABLE];
  assign xmode    = control_reg[`HCUR_CTRL_XMODE];
  assign pat_base = pat_base_reg[`HCUR_PAT_BASE_MSB:`HCUR_PAT_BASE_LSB];
  assign pos_x    = position_reg[`HCUR_POS_X_MSB:`HCUR_POS_X_LSB];
  assign pos_y    = position_reg[`HCUR_POS_Y_MSB:`HCUR_POS_Y_LSB];
  assign colour0  = {colour0_reg[`HCUR_COL_RED_MSB:`HCUR_COL_RED_LSB],
                     colour0_reg[`HCUR_COL_GREEN_MSB:`HCUR_COL_GREEN_LSB],
                     colour0_reg[`HCUR_COL_BLUE_MSB:`HCUR_COL_BLUE_LSB]};
  assign colour1  = {colour1_reg[`HCUR_COL_RED_MSB:`HCUR_COL_RED_LSB],
                     colour1_reg[`HCUR_COL_GREEN_MSB:`HCUR_COL_GREEN_LSB],
                     colour1_reg[`HCUR_COL_BLUE_MSB:`HCUR_COL_BLUE_LSB]};

  // byte-lane write mask, one lane per generate pass
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1)
    begin : g_lane
      assign be_mask[lane*8 +: 8] = {8{avs_byteenable_i[lane]}};
    end
  endgenerate

  // reads take one wait cycle so read data comes from a flop
  assign avs_waitrequest_o = avs_read_i & ~rd_ack_reg;
  assign avs_readdata_o    = rdata_reg;
  assign wr_sel            = avs_write_i & ~avs_read_i;
  assign rd_sel            = avs_read_i & ~rd_ack_reg;

  // register writes; unmapped addresses are ignored
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pat_base_reg <= `HCUR_RST_PAT_BASE;
      position_reg <= `HCUR_RST_POSITION;
      colour0_reg  <= `HCUR_RST_COLOUR;
      colour1_reg  <= `HCUR_RST_COLOUR;
      control_reg  <= `HCUR_RST_CONTROL;
    end
    else if (wr_sel)
    begin
      if (avs_address_i == `HCUR_OFS_PAT_BASE)
        pat_base_reg <= (pat_base_reg & ~be_mask) | (avs_writedata_i & be_mask & 32'h00ff_ffff);
      else if (avs_address_i == `HCUR_OFS_POSITION)
        position_reg <= (position_reg & ~be_mask) | (avs_writedata_i & be_mask & 32'h07ff_07ff);
      else if (avs_address_i == `HCUR_OFS_COLOUR0)
        colour0_reg <= (colour0_reg & ~be_mask) | (avs_writedata_i & be_mask & 32'h00ff_ffff);
      else if (avs_address_i == `HCUR_OFS_COLOUR1)
        colour1_reg <= (colour1_reg & ~be_mask) | (avs_writedata_i & be_mask & 32'h00ff_ffff);
      else if (avs_address_i == `HCUR_OFS_CONTROL)
        control_reg <= (control_reg & ~be_mask) | (avs_writedata_i & be_mask & 32'h0000_0003);
    end
  end

  // read data capture; unmapped addresses read as zero
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_ack_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      rd_ack_reg <= rd_sel;
      if (rd_sel)
      begin
        if (avs_address_i == `HCUR_OFS_PAT_BASE)
          rdata_reg <= pat_base_reg;
        else if (avs_address_i == `HCUR_OFS_POSITION)
          rdata_reg <= position_reg;
        else if (avs_address_i == `HCUR_OFS_COLOUR0)
          rdata_reg <= colour0_reg;
        else if (avs_address_i == `HCUR_OFS_COLOUR1)
          rdata_reg <= colour1_reg;
        else if (avs_address_i == `HCUR_OFS_CONTROL)
          rdata_reg <= control_reg;
        else if (avs_address_i == `HCUR_OFS_STATUS)
          rdata_reg <= {21'h00_0000, buf_group_reg, 6'h00, buf_valid_reg, (state_reg != ST_IDLE)}; // group in 10:8
        else
          rdata_reg <= 32'h0000_0000;
      end
    end
  end

  // vertical extent test for the upcoming line, y-63..y
  // unsigned compare first so a cursor near line 0 clips cleanly
  assign retrace_rise = hretrace_i & ~retrace_d_reg;
  assign dy           = pos_y - next_line_i;
  assign line_cover   = enable & (next_line_i <= pos_y) & (dy <= 11'h03f);
  assign line_idx     = ~dy[5:0]; // 63 - dy, row inside the pattern
  assign line_group   = line_idx[5:3]; // eight lines per fetched group
  assign need_fetch   = retrace_rise & line_cover &
                        ~(buf_valid_reg & (buf_group_reg == line_group));

  // fetch state machine, next state
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (need_fetch)
        begin
          state_next = ST_REQ;
        end
      end
      ST_REQ:
      begin
        if (~mem_waitrequest_i)
        begin
          state_next = ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (mem_readdatavalid_i && (wcnt_reg == 3'h7))
        begin
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // fetch state machine, registers
  // a burst once issued always drains, even if software disables the cursor
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg     <= ST_IDLE;
      mem_read_reg  <= 1'b0;
      mem_addr_reg  <= 24'h00_0000;
      wcnt_reg      <= 3'h0;
      buf_valid_reg <= 1'b0;
      buf_group_reg <= 3'h0;
      retrace_d_reg <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      retrace_d_reg <= hretrace_i;
      if ((state_reg == ST_IDLE) && need_fetch)
      begin
        mem_read_reg  <= 1'b1;
        mem_addr_reg  <= pat_base + {14'h0000, line_group, 7'h00}; // group * 8 lines * 16 bytes
        buf_valid_reg <= 1'b0;
        buf_group_reg <= line_group;
        wcnt_reg      <= 3'h0;
      end
      else if ((state_reg == ST_REQ) && ~mem_waitrequest_i)
      begin
        mem_read_reg <= 1'b0;
      end
      else if ((state_reg == ST_DATA) && mem_readdatavalid_i)
      begin
        wcnt_reg <= wcnt_reg + 3'h1;
        if (wcnt_reg == 3'h7)
        begin
          buf_valid_reg <= 1'b1;
        end
      end
      // a new base makes the buffered lines stale
      if (wr_sel && (avs_address_i == `HCUR_OFS_PAT_BASE) && (state_reg == ST_IDLE) && ~need_fetch)
      begin
        buf_valid_reg <= 1'b0;
      end
    end
  end

  assign mem_read_o       = mem_read_reg;
  assign mem_address_o    = mem_addr_reg;
  assign mem_burstcount_o = `HCUR_BURST_COUNT; // eight consecutive words
  assign ram_we           = (state_reg == ST_DATA) & mem_readdatavalid_i;

  // latch per-line hit and row at retrace
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      line_hit_reg <= 1'b0;
      line_idx_reg <= 6'h00;
    end
    else if (retrace_rise)
    begin
      line_hit_reg <= line_cover;
      line_idx_reg <= line_idx;
    end
  end

  // on-chip store for one group of eight pattern lines
  hcur_pat_ram u_pat_ram (
    .clk_i     (clk_i),
    .wr_en_i   (ram_we),
    .wr_addr_i (wcnt_reg),
    .wr_data_i (mem_readdata_i),
    .rd_addr_i (line_idx_reg[2:0]),
    .rd_data_o (ram_word)
  );

  // horizontal extent, x-63..x; bit 0 of a shape is its leftmost pixel
  assign dx        = pos_x - pix_x_i;
  assign col_cover = (pix_x_i <= pos_x) & (dx <= 11'h03f);
  assign col_idx   = ~dx[5:0];
  assign bit_s0    = ram_word[col_idx]; // shape zero in the low half
  assign bit_s1    = ram_word[{1'b1, col_idx}]; // shape one in the high half
  assign show      = enable & line_hit_reg & col_cover & buf_valid_reg &
                     (buf_group_reg == line_idx_reg[5:3]);

  // colour mapping; a line whose data is not yet in passes the screen
  always @*
  begin
    mix_rgb = pix_rgb_i;
    if (show)
    begin
      if (~xmode)
      begin
        case ({bit_s0, bit_s1})
          2'b00: mix_rgb = colour0;
          2'b01: mix_rgb = colour1;
          2'b10: mix_rgb = pix_rgb_i;
          default: mix_rgb = ~pix_rgb_i;
        endcase
      end
      else
      begin
        case ({bit_s0, bit_s1})
          2'b10: mix_rgb = colour0;
          2'b11: mix_rgb = colour1;
          default: mix_rgb = pix_rgb_i;
        endcase
      end
    end
  end

  // pixel output stage, one clock of latency
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pix_valid_reg <= 1'b0;
      pix_rgb_reg   <= 24'h00_0000;
    end
    else
    begin
      pix_valid_reg <= pix_valid_i;
      pix_rgb_reg   <= mix_rgb;
    end
  end

  assign pix_valid_o = pix_valid_reg;
  assign pix_rgb_o   = pix_rgb_reg;

endmodule

// *** hcur_defines.vh ***
`ifndef HCUR_DEFINES_VH
`define HCUR_DEFINES_VH

// register byte offsets on the avalon slave
`define HCUR_OFS_PAT_BASE   5'h00
`define HCUR_OFS_POSITION   5'h04
`define HCUR_OFS_COLOUR0    5'h08
`define HCUR_OFS_COLOUR1    5'h0c
`define HCUR_OFS_CONTROL    5'h10
`define HCUR_OFS_STATUS     5'h14

// field positions
`define HCUR_PAT_BASE_MSB   23
`define HCUR_PAT_BASE_LSB   0
`define HCUR_POS_X_MSB      10
`define HCUR_POS_X_LSB      0
`define HCUR_POS_Y_MSB      26
`define HCUR_POS_Y_LSB      16
`define HCUR_COL_BLUE_MSB   7
`define HCUR_COL_BLUE_LSB   0
`define HCUR_COL_GREEN_MSB  15
`define HCUR_COL_GREEN_LSB  8
`define HCUR_COL_RED_MSB    23
`define HCUR_COL_RED_LSB    16
`define HCUR_CTRL_ENABLE    0
`define HCUR_CTRL_XMODE     1

// reset values
`define HCUR_RST_PAT_BASE   32'h0000_0000
`define HCUR_RST_POSITION   32'h0000_0000
`define HCUR_RST_COLOUR     32'h0000_0000
`define HCUR_RST_CONTROL    32'h0000_0000

// pattern geometry and fetch counts
`define HCUR_SHAPE_SIZE     64
`define HCUR_FETCH_WORDS    8
`define HCUR_LINE_STRIDE    16
`define HCUR_BURST_COUNT    4'h8
`define HCUR_GROUP_BYTES    (`HCUR_FETCH_WORDS * `HCUR_LINE_STRIDE)

`endif

// *** hcur_pat_ram.v ***
`timescale 1ns/1ps
`include "hcur_defines.vh"

module hcur_pat_ram (
  input  wire         clk_i,
  input  wire         wr_en_i,
  input  wire [2:0]   wr_addr_i,
  input  wire [127:0] wr_data_i,
  input  wire [2:0]   rd_addr_i,
  output wire [127:0] rd_data_o
);

  // eight pattern lines, one 128-bit word each
  reg [127:0] mem_reg [0:`HCUR_FETCH_WORDS-1];
  reg [127:0] rd_data_reg;

  // write port, filled by the burst fetch
  always @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read; the address is stable for a whole scanline
  always @(posedge clk_i)
  begin
    rd_data_reg <= mem_reg[rd_addr_i];
  end

  assign rd_data_o = rd_data_reg;

endmodule

// *** hcur_mem_model.sv ***
`timescale 1ns/1ps

module hcur_mem_model (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [3:0]   stall_i,
  input  wire         mem_read_i,
  output wire         waitrequest_o,
  output reg  [127:0] readdata_o,
  output reg          readdatavalid_o
);
  // each pair code fills its own 16-column quarter of a line
  localparam [127:0] LINE = {64'h0000_ffff_0000_ffff, 64'h0000_0000_ffff_ffff};
  reg [3:0] wait_reg;
  reg [3:0] left_reg;

  // a running burst refuses the next request
  assign waitrequest_o = (wait_reg != stall_i) || (left_reg != 4'h0);

  // stall, then return eight words back to back; idle data keeps toggling
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wait_reg <= 4'h0;
      left_reg <= 4'h0;
      readdatavalid_o <= 1'b0;
      readdata_o <= 128'h0;
    end
    else
    begin
      readdatavalid_o <= left_reg != 4'h0;
      readdata_o <= (left_reg != 4'h0) ? LINE : ~readdata_o;
      if (mem_read_i && !waitrequest_o)
      begin
        wait_reg <= 4'h0;
        left_reg <= 4'h8;
      end
      else if (left_reg != 4'h0)
        left_reg <= left_reg - 4'h1;
      else if (mem_read_i)
        wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// *** hcur_overlay_props.sv ***
`timescale 1ns/1ps
`include "hcur_defines.vh"

module hcur_overlay_props (
  input wire         clk_i,
  input wire         rst_i,
  input wire [4:0]   avs_address_i,
  input wire         avs_write_i,
  input wire [31:0]  avs_writedata_i,
  input wire [3:0]   avs_byteenable_i,
  input wire         hretrace_i,
  input wire [10:0]  next_line_i,
  input wire         mem_read_o,
  input wire [23:0]  mem_address_o,
  input wire [3:0]   mem_burstcount_o,
  input wire         mem_waitrequest_i,
  input wire         pix_valid_i,
  input wire [10:0]  pix_x_i,
  input wire [23:0]  pix_rgb_i,
  input wire [23:0]  pix_rgb_o
);
  reg  [31:0] base_reg;
  reg  [31:0] pos_reg;
  reg  [31:0] ctrl_reg;
  wire [31:0] lane_w;
  wire [23:0] ofs_w;

  // shadow copies, since the registers themselves are out of sight
  assign lane_w = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}}, {8{avs_byteenable_i[1]}},
                   {8{avs_byteenable_i[0]}}};
  assign ofs_w = mem_address_o - base_reg[23:0];
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      base_reg <= 32'h0;
      pos_reg <= 32'h0;
      ctrl_reg <= 32'h0;
    end
    else if (avs_write_i)
    begin
      if (avs_address_i == `HCUR_OFS_PAT_BASE)
        base_reg <= (base_reg & ~lane_w) | (avs_writedata_i & lane_w);
      if (avs_address_i == `HCUR_OFS_POSITION)
        pos_reg <= (pos_reg & ~lane_w) | (avs_writedata_i & lane_w);
      if (avs_address_i == `HCUR_OFS_CONTROL)
        ctrl_reg <= (ctrl_reg & ~lane_w) | (avs_writedata_i & lane_w);
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_burst_eight: assert property (mem_read_o |-> mem_burstcount_o == `HCUR_BURST_COUNT)
    else $error("burst count is not eight");
  a_req_held: assert property (mem_read_o && mem_waitrequest_i |=> mem_read_o && $stable(mem_address_o))
    else $error("fetch request dropped or moved while stalled");
  a_fetch_on_retrace: assert property ($rose(mem_read_o) |-> $past(hretrace_i) && !$past(hretrace_i, 2))
    else $error("fetch not one cycle after retrace start");
  a_miss_line: assert property ($rose(hretrace_i) && !mem_read_o && next_line_i > pos_reg[26:16] |=> !mem_read_o)
    else $error("fetch for a line below the cursor");
  a_addr_linear: assert property ($rose(mem_read_o) |-> ofs_w[6:0] == 7'h0 && ofs_w[23:10] == 14'h0)
    else $error("fetch address off the linear group grid");
  a_off_no_fetch: assert property ($rose(mem_read_o) |-> $past(ctrl_reg[0]))
    else $error("fetch while cursor disabled");
  a_off_pass: assert property (pix_valid_i && !ctrl_reg[0] |=> pix_rgb_o == $past(pix_rgb_i))
    else $error("pixel altered while cursor disabled");
  a_right_clip: assert property (pix_valid_i && pix_x_i > pos_reg[10:0] |=> pix_rgb_o == $past(pix_rgb_i))
    else $error("pixel right of cursor altered");
  a_left_clip: assert property (pix_valid_i && {1'b0, pix_x_i} + 12'd63 < {1'b0, pos_reg[10:0]}
    |=> pix_rgb_o == $past(pix_rgb_i))
    else $error("pixel left of cursor altered");

  c_fetch: cover property ($rose(mem_read_o));
  c_stalled: cover property (mem_read_o && mem_waitrequest_i);
  c_hit: cover property (pix_valid_i && ctrl_reg[0] && pix_x_i <= pos_reg[10:0]);
endmodule

bind hcur_overlay hcur_overlay_props hcur_overlay_props_inst (.clk_i, .rst_i, .avs_address_i, .avs_write_i,
  .avs_writedata_i, .avs_byteenable_i, .hretrace_i, .next_line_i, .mem_read_o, .mem_address_o, .mem_burstcount_o,
  .mem_waitrequest_i, .pix_valid_i, .pix_x_i, .pix_rgb_i, .pix_rgb_o);

// *** hcur_overlay_test.sv ***
`timescale 1ns/1ps
`include "hcur_defines.vh"

module hcur_overlay_test;
  localparam [23:0] SCR  = 24'h0a0b0c;
  localparam [23:0] COL0 = 24'h102030;
  localparam [23:0] COL1 = 24'h405060;
  localparam [23:0] BASE = 24'h012340;
  reg          clk_i = 1'b0;
  reg          rst_i = 1'b1;
  reg  [4:0]   avs_address_i = 5'h0;
  reg          avs_read_i = 1'b0;
  reg          avs_write_i = 1'b0;
  reg  [31:0]  avs_writedata_i = 32'h0;
  reg  [3:0]   avs_byteenable_i = 4'hf;
  reg          hretrace_i = 1'b0;
  reg  [10:0]  next_line_i = 11'h0;
  reg          pix_valid_i = 1'b0;
  reg  [10:0]  pix_x_i = 11'h0;
  reg  [23:0]  pix_rgb_i = SCR;
  reg  [3:0]   stall = 4'h0;
  wire [31:0]  avs_readdata_o;
  wire         avs_waitrequest_o;
  wire         mem_read_o;
  wire [23:0]  mem_address_o;
  wire [3:0]   mem_burstcount_o;
  wire         mem_waitrequest_i;
  wire [127:0] mem_readdata_i;
  wire         mem_readdatavalid_i;
  wire         pix_valid_o;
  wire [23:0]  pix_rgb_o;
  integer      mismatches = 0;
  integer      check_count = 0;
  integer      cycles = 0;
  integer      fetches = 0;
  reg  [31:0]  faddr = 32'h0;
  reg  [31:0]  q;
  integer      i;

  hcur_overlay hcur_overlay_inst (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .hretrace_i, .next_line_i, .mem_read_o, .mem_address_o,
    .mem_burstcount_o, .mem_waitrequest_i, .mem_readdata_i, .mem_readdatavalid_i, .pix_valid_i, .pix_x_i,
    .pix_rgb_i, .pix_valid_o, .pix_rgb_o);
  hcur_mem_model hcur_mem_model_inst (.clk_i, .rst_i, .stall_i(stall), .mem_read_i(mem_read_o),
    .waitrequest_o(mem_waitrequest_i), .readdata_o(mem_readdata_i), .readdatavalid_o(mem_readdatavalid_i));

  always #5 clk_i = ~clk_i;

  // count accepted bursts; also cut a hang short
  always @(posedge clk_i)
  begin
    cycles = cycles + 1;
    if (mem_read_o && !mem_waitrequest_i)
    begin
      fetches = fetches + 1;
      faddr = {8'h0, mem_address_o};
    end
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: timeout", $time);
      finish_test;
    end
  end

  task finish_test;
  begin
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  end
  endtask

  // one avalon transfer; the request holds until waitrequest is seen low
  task av(input w, input [4:0] a, input [31:0] d, output [31:0] rq);
  begin
    @(posedge clk_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clk_i);
    rq = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  end
  endtask

  task rd(input [4:0] a, input [31:0] exp);
    reg [31:0] rq;
  begin
    av(1'b0, a, 32'h0, rq);
    chk(rq, exp);
  end
  endtask

  // start a retrace, then poll the busy flag (bounded) until the burst drains
  task retr(input [10:0] l);
    integer n;
    reg [31:0] rq;
  begin
    @(posedge clk_i);
    hretrace_i <= 1'b1;
    next_line_i <= l;
    repeat (2) @(posedge clk_i);
    hretrace_i <= 1'b0;
    rq = 32'h1;
    for (n = 0; n < 30 && rq[0]; n = n + 1)
      av(1'b0, `HCUR_OFS_STATUS, 32'h0, rq);
  end
  endtask

  function [23:0] mix(input [10:0] px, input [10:0] cx, input m);
    integer c;
    reg s0;
    reg s1;
  begin
    c = px - cx + 63;
    s0 = c < 32;
    s1 = c < 16 || (c >= 32 && c < 48);
    if (c < 0 || c > 63)
      mix = SCR;
    else if (!m)
      mix = s0 ? (s1 ? ~SCR : SCR) : (s1 ? COL1 : COL0);
    else
      mix = !s0 ? SCR : (s1 ? COL1 : COL0);
  end
  endfunction

  task pix(input [10:0] x, input [23:0] exp);
  begin
    @(posedge clk_i);
    pix_valid_i <= 1'b1;
    pix_x_i <= x;
    @(posedge clk_i);
    pix_valid_i <= 1'b0;
    #1;
    chk({7'h0, pix_valid_o, pix_rgb_o}, {8'h1, exp});
  end
  endtask

  // fourteen pixels five apart, reaching one past each cursor edge
  task sweep(input m, input [10:0] cx, input [10:0] px0);
    integer k;
  begin
    for (k = 0; k < 14; k = k + 1)
      pix(px0 + 11'(k * 5), mix(px0 + 11'(k * 5), cx, m));
  end
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 7; i = i + 1)
      rd(5'(i * 4), 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      av(1'b1, 5'(i * 4), 32'hffff_ffff, q);
      rd(5'(i * 4), i == 1 ? 32'h07ff_07ff : 32'h00ff_ffff);
    end
    av(1'b1, 5'h18, 32'hffff_ffff, q);
    rd(5'h18, 32'h0);
    // only the green lane may change
    avs_byteenable_i <= 4'h2;
    av(1'b1, `HCUR_OFS_COLOUR0, 32'h0, q);
    avs_byteenable_i <= 4'hf;
    rd(`HCUR_OFS_COLOUR0, 32'h00ff_00ff);
    av(1'b1, `HCUR_OFS_PAT_BASE, {8'h0, BASE}, q);
    av(1'b1, `HCUR_OFS_COLOUR0, {8'h0, COL0}, q);
    av(1'b1, `HCUR_OFS_COLOUR1, {8'h0, COL1}, q);
    av(1'b1, `HCUR_OFS_POSITION, 32'h0064_0064, q);
    av(1'b1, `HCUR_OFS_CONTROL, 32'h1, q);
    retr(11'd37);
    chk(fetches, 1);
    chk(faddr, {8'h0, BASE});
    rd(`HCUR_OFS_STATUS, 32'h0000_0002);
    sweep(1'b0, 11'd100, 11'd36);
    // second convention, slow memory, next group
    av(1'b1, `HCUR_OFS_CONTROL, 32'h3, q);
    stall <= 4'h5;
    retr(11'd45);
    chk(faddr, {8'h0, BASE + 24'd128});
    sweep(1'b1, 11'd100, 11'd36);
    retr(11'd46);
    chk(fetches, 2);
    // cursor hanging off the left edge, last line of the pattern
    av(1'b1, `HCUR_OFS_CONTROL, 32'h1, q);
    av(1'b1, `HCUR_OFS_POSITION, 32'h0064_001e, q);
    retr(11'd100);
    chk(faddr, {8'h0, BASE + 24'd896});
    rd(`HCUR_OFS_STATUS, 32'h0000_0702);
    sweep(1'b0, 11'd30, 11'd0);
    retr(11'd101);
    chk(fetches, 3);
    pix(11'd10, SCR);
    av(1'b1, `HCUR_OFS_CONTROL, 32'h0, q);
    retr(11'd40);
    chk(fetches, 3);
    pix(11'd10, SCR);
    finish_test;
  end
endmodule
